// ---- pmp_consts.svh ----
// Named constants for the program memory protection block.
// Assumes a 10 MHz ref_clk, an APB master and a 4K-word program array.
`ifndef PMP_CONSTS_SVH
`define PMP_CONSTS_SVH
`define PMP_PC_W        15
`define PMP_AW          12
`define PMP_WORD_W      14
`define PMP_EXT_AW      16
`define PMP_RESET_VEC   15'h0000
`define PMP_IRQ_VEC     15'h0004
`define PMP_PC_STEP     15'h0001
`define PMP_HE_BASE     12'hF80
`define PMP_WRT_BOUND_2 13'h0200
`define PMP_WRT_BOUND_1 13'h0800
`define PMP_WRT_BOUND_0 13'h1000
`define PMP_WRT_NONE    2'h3
`define PMP_WRT_SMALL   2'h2
`define PMP_WRT_HALF    2'h1
`define PMP_CFG_BLANK   14'h3FFF
`define PMP_CFG_UNIMPL  14'h01FC
`define PMP_CFG_LVP_BIT 13
`define PMP_UID_BASE    16'h8000
`define PMP_CFG2_ADDR   16'h8007
`define PMP_CFG_SPACE   15
`define PMP_OFF_CFG     12'h000
`define PMP_OFF_STATUS  12'h004
`define PMP_OFF_CTRL    12'h008
`define PMP_OFF_UID0    12'h010
`define PMP_UID_MASK    12'hFF3
`define PMP_UID_SEL_LSB 2
`define PMP_ST_REFUSED  0
`define PMP_ST_DEDIC    1
`define PMP_ST_LVPENT   2
`define PMP_ST_LOCKN    3
`define PMP_ST_PC_LSB   16
`define PMP_CTRL_SWEN   0
`define PMP_ZERO32      32'h0000_0000
`endif

// ---- pmp_pkg.sv ----
// Types shared by the program memory protection block.
// Assumes pmp_consts.svh is compiled alongside it.
package pmp_pkg;
  // Second configuration word as it is laid out in the array.
  typedef struct packed {
    logic       low_volt_prog_enable;
    logic       debug_n;
    logic       low_power_brownout_off;
    logic       borv;
    logic       stvren;
    logic [6:0] unimpl;
    logic [1:0] self_write_guard_size;
  } pmp_cfg_t;

  // One request from the programmer front end, a single-cycle strobe.
  typedef struct packed {
    logic        valid;
    logic        we;
    logic        erase;
    logic [15:0] addr;
    logic [13:0] wdata;
  } pmp_ext_req_t;

  // Self-write request from the core.
  typedef struct packed {
    logic        valid;
    logic [14:0] addr;
    logic [13:0] wdata;
  } pmp_sw_req_t;

  // Source of the data returned to the programmer.
  typedef enum logic [1:0] {SRC_PM, SRC_UID, SRC_CFG, SRC_NONE} pmp_src_t;
endpackage

// ---- pmp_protect.sv ----
// Program memory protection and organisation logic with an APB register slave.
// Assumes a single ref_clk domain; the array, core and programmer front end share it,
// while the two serial programming pins come from outside and are synchronised here.
`include "pmp_consts.svh"
`timescale 1ns/1ns
`default_nettype none
module pmp_protect (
  input  wire logic                 ref_clk,
  input  wire logic                 rst_n,
  input  wire logic [11:0]          paddr,
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [31:0]          pwdata,
  output logic      [31:0]          prdata,
  output logic                      pready,
  output logic                      pslverr,
  input  wire logic                 core_pc_inc,
  input  wire logic                 core_pc_load,
  input  wire logic [14:0]          core_pc_target,
  input  wire logic                 irq_accept,
  output logic      [11:0]          fetch_addr,
  input  wire pmp_pkg::pmp_sw_req_t sw_req,
  output logic                      sw_done,
  output logic                      sw_refused,
  output logic                      mem_we,
  output logic      [11:0]          mem_waddr,
  output logic      [13:0]          mem_wdata,
  output logic                      mem_he_region,
  output logic                      mem_bulk_erase,
  input  wire pmp_pkg::pmp_ext_req_t ext_req,
  input  wire logic                 lvp_entry,
  output logic                      ext_ack,
  output logic      [13:0]          ext_rdata,
  output logic                      ext_refused,
  output logic      [11:0]          ext_mem_addr,
  input  wire logic [13:0]          ext_mem_rdata,
  input  wire logic [13:0]          cfg_nv_word,
  input  wire logic                 external_access_lock_n,
  output logic                      nv_cfg_we,
  output logic      [13:0]          nv_cfg_wdata,
  output logic                      hv_prog_required,
  output logic                      low_power_brownout_off_enable,
  output logic                      debug_dedicated,
  input  wire logic                 serial_prog_clock_pin_i,
  output logic                      serial_prog_clock_pin_o,
  output logic                      serial_prog_clock_pin_oe,
  input  wire logic                 serial_prog_data_pin_i,
  output logic                      serial_prog_data_pin_o,
  output logic                      serial_prog_data_pin_oe,
  input  wire logic [1:0]           gpio_out,
  input  wire logic [1:0]           gpio_oe,
  output logic      [1:0]           gpio_in,
  input  wire logic [1:0]           dbg_out,
  input  wire logic [1:0]           dbg_oe,
  output logic      [1:0]           dbg_in
);

  // Running copy of the configuration; blank until the first edge after reset.
  pmp_pkg::pmp_cfg_t cfg_reg;
  logic              cfg_load_reg;
  logic              lock_n_reg;
  logic [14:0]       pc_reg;
  logic [14:0]       pc_next;
  logic              swen_reg;
  logic              refused_st_reg;
  logic [13:0]       uid_reg [4];
  logic [13:0]       prdata_next;

  // Configuration capture happens by clock after reset release, never through the
  // asynchronous reset, so the array word cannot leak into the reset path.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_reg      <= `PMP_CFG_BLANK;
      lock_n_reg   <= 1'b1;
      cfg_load_reg <= 1'b1;
    end else if (cfg_load_reg) begin
      cfg_reg      <= cfg_nv_word | `PMP_CFG_UNIMPL;
      lock_n_reg   <= external_access_lock_n;
      cfg_load_reg <= 1'b0;
    end
  end

  // Fixed-function outputs decoded from the held configuration.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      hv_prog_required <= 1'b0;
      low_power_brownout_off_enable     <= 1'b0;
      debug_dedicated  <= 1'b0;
    end else begin
      hv_prog_required <= ~cfg_reg.low_volt_prog_enable;
      low_power_brownout_off_enable     <= ~cfg_reg.low_power_brownout_off;
      debug_dedicated  <= ~cfg_reg.debug_n;
    end
  end

  // Program counter: interrupt beats a jump, a jump beats a step.
  always_comb begin
    pc_next = pc_reg;
    if (irq_accept) begin
      pc_next = `PMP_IRQ_VEC;
    end else if (core_pc_load) begin
      pc_next = core_pc_target;
    end else if (core_pc_inc) begin
      pc_next = pc_reg + `PMP_PC_STEP;
    end
  end

  // Fetch is never gated by any protection setting; only the low bits reach the array.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pc_reg     <= `PMP_RESET_VEC;
      fetch_addr <= 12'(`PMP_RESET_VEC);
    end else begin
      pc_reg     <= pc_next;
      fetch_addr <= pc_next[`PMP_AW-1:0];
    end
  end

  // Self-write guard: the shielded block always starts at word zero.
  logic [12:0] wrt_bound;
  logic [11:0] sw_waddr;
  logic        sw_in_guard;
  logic        ext_is_cfg;
  logic        ext_is_pm;
  logic        ext_pm_write;
  logic        sw_ok;
  assign wrt_bound = (cfg_reg.self_write_guard_size == `PMP_WRT_SMALL) ? `PMP_WRT_BOUND_2 :
                     (cfg_reg.self_write_guard_size == `PMP_WRT_HALF)  ? `PMP_WRT_BOUND_1 :
                     `PMP_WRT_BOUND_0;
  assign sw_waddr    = sw_req.addr[`PMP_AW-1:0];
  assign sw_in_guard = (cfg_reg.self_write_guard_size != `PMP_WRT_NONE)
                     && ({1'b0, sw_waddr} < wrt_bound);
  assign ext_is_cfg  = ext_req.addr[`PMP_CFG_SPACE];
  assign ext_is_pm   = ~ext_is_cfg;
  assign ext_pm_write = ext_req.valid & ext_req.we & ~ext_req.erase & ext_is_pm & lock_n_reg;
  // The external lock plays no part here; a programmer write takes the port first.
  assign sw_ok = sw_req.valid & swen_reg & ~sw_in_guard & ~ext_pm_write;

  // Array write port, shared by the programmer and self-writes.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      mem_we         <= 1'b0;
      mem_waddr      <= 12'h000;
      mem_wdata      <= 14'h0000;
      mem_he_region  <= 1'b0;
      mem_bulk_erase <= 1'b0;
      sw_done        <= 1'b0;
      sw_refused     <= 1'b0;
    end else begin
      mem_we         <= ext_pm_write | sw_ok;
      mem_bulk_erase <= ext_req.valid & ext_req.erase;
      sw_done        <= sw_ok;
      sw_refused     <= sw_req.valid & ~sw_ok;
      if (ext_pm_write) begin
        mem_waddr     <= ext_req.addr[`PMP_AW-1:0];
        mem_wdata     <= ext_req.wdata;
        mem_he_region <= ext_req.addr[`PMP_AW-1:0] >= `PMP_HE_BASE;
      end else if (sw_ok) begin
        mem_waddr     <= sw_waddr;
        mem_wdata     <= sw_req.wdata;
        mem_he_region <= sw_waddr >= `PMP_HE_BASE;
      end
    end
  end

  // Programmer configuration writes; the low-voltage bit cannot be cleared
  // while the device was entered by the low-voltage method.
  logic        ext_cfg_write;
  logic        lvp_clear_refused;
  logic [13:0] ext_cfg_word;
  assign ext_cfg_write = ext_req.valid & ext_req.we & ~ext_req.erase
                       & (ext_req.addr == `PMP_CFG2_ADDR);
  assign lvp_clear_refused = ext_cfg_write & lvp_entry
                           & ~ext_req.wdata[`PMP_CFG_LVP_BIT];
  always_comb begin
    ext_cfg_word = ext_req.wdata | `PMP_CFG_UNIMPL;
    if (lvp_entry) begin
      ext_cfg_word[`PMP_CFG_LVP_BIT] = 1'b1;
    end
  end

  // Writes to the array image only; the running copy waits for the next reset.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      nv_cfg_we    <= 1'b0;
      nv_cfg_wdata <= `PMP_CFG_BLANK;
    end else begin
      nv_cfg_we    <= ext_cfg_write | (ext_req.valid & ext_req.erase);
      nv_cfg_wdata <= ext_req.erase ? `PMP_CFG_BLANK : ext_cfg_word;
    end
  end

  // Programmer read pipeline: address out on the first edge, data back on the second.
  pmp_pkg::pmp_src_t ext_src_reg;
  logic              ext_p1_reg;
  logic              ext_ref_p1_reg;
  logic [13:0]       ext_hold_reg;
  pmp_pkg::pmp_src_t ext_src_next;
  logic [1:0]        ext_uid_sel;
  logic              ext_is_uid;
  assign ext_uid_sel = ext_req.addr[1:0];
  assign ext_is_uid  = ext_is_cfg && ((ext_req.addr & ~16'h0003) == `PMP_UID_BASE);
  assign ext_src_next = ext_is_pm ? pmp_pkg::SRC_PM :
                        ext_is_uid ? pmp_pkg::SRC_UID :
                        (ext_req.addr == `PMP_CFG2_ADDR) ? pmp_pkg::SRC_CFG :
                        pmp_pkg::SRC_NONE;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ext_p1_reg     <= 1'b0;
      ext_ref_p1_reg <= 1'b0;
      ext_src_reg    <= pmp_pkg::SRC_NONE;
      ext_hold_reg   <= 14'h0000;
      ext_mem_addr   <= 12'h000;
    end else begin
      ext_p1_reg     <= ext_req.valid;
      ext_ref_p1_reg <= (ext_req.valid & ext_req.we & ~ext_req.erase & ext_is_pm & ~lock_n_reg)
                      | lvp_clear_refused;
      ext_src_reg    <= ext_src_next;
      ext_hold_reg   <= (ext_src_next == pmp_pkg::SRC_UID) ? uid_reg[ext_uid_sel] : cfg_nv_word;
      if (ext_req.valid) begin
        ext_mem_addr <= ext_req.addr[`PMP_AW-1:0];
      end
    end
  end

  // Answer stage; a locked array reads as all zeros to the programmer.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ext_ack     <= 1'b0;
      ext_rdata   <= 14'h0000;
      ext_refused <= 1'b0;
    end else begin
      ext_ack     <= ext_p1_reg;
      ext_refused <= ext_ref_p1_reg;
      case (ext_src_reg)
        pmp_pkg::SRC_PM:  ext_rdata <= lock_n_reg ? ext_mem_rdata : 14'h0000;
        pmp_pkg::SRC_UID: ext_rdata <= ext_hold_reg;
        pmp_pkg::SRC_CFG: ext_rdata <= ext_hold_reg | `PMP_CFG_UNIMPL;
        default:          ext_rdata <= 14'h0000;
      endcase
    end
  end

  // Serial pin inputs: three stages, and a change is taken once stages two and three agree.
  // Outputs are picked by the debugger bit so the port logic never fights the debugger.
  logic [1:0] pin_i;
  logic [1:0] pin_o;
  logic [1:0] pin_oe;
  assign pin_i = {serial_prog_data_pin_i, serial_prog_clock_pin_i};
  assign serial_prog_clock_pin_o  = pin_o[0];
  assign serial_prog_clock_pin_oe = pin_oe[0];
  assign serial_prog_data_pin_o   = pin_o[1];
  assign serial_prog_data_pin_oe  = pin_oe[1];

  for (genvar g = 0; g < 2; g++) begin : g_pin
    logic s1_reg;
    logic s2_reg;
    logic s3_reg;
    logic filt_reg;
    logic out_reg;
    logic oe_reg;
    logic gin_reg;
    logic din_reg;
    always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
        s1_reg   <= 1'b0;
        s2_reg   <= 1'b0;
        s3_reg   <= 1'b0;
        filt_reg <= 1'b0;
      end else begin
        s1_reg <= pin_i[g];
        s2_reg <= s1_reg;
        s3_reg <= s2_reg;
        if (s2_reg == s3_reg) begin
          filt_reg <= s3_reg;
        end
      end
    end
    // Pin direction and data follow the running debugger bit.
    always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
        out_reg <= 1'b0;
        oe_reg  <= 1'b0;
        gin_reg <= 1'b0;
        din_reg <= 1'b0;
      end else begin
        out_reg <= cfg_reg.debug_n ? gpio_out[g] : dbg_out[g];
        oe_reg  <= cfg_reg.debug_n ? gpio_oe[g]  : dbg_oe[g];
        gin_reg <= cfg_reg.debug_n & filt_reg;
        din_reg <= ~cfg_reg.debug_n & filt_reg;
      end
    end
    assign pin_o[g]   = out_reg;
    assign pin_oe[g]  = oe_reg;
    assign gpio_in[g] = gin_reg;
    assign dbg_in[g]  = din_reg;
  end

  // APB decode; the answer is ready in the first access cycle.
  logic       apb_setup;
  logic       apb_wr;
  logic       hit_cfg;
  logic       hit_status;
  logic       hit_ctrl;
  logic       hit_uid;
  logic [1:0] uid_sel;
  logic       hit_any;
  assign apb_setup  = psel & ~penable;
  assign apb_wr     = psel & penable & pwrite & pready;
  assign hit_cfg    = paddr == `PMP_OFF_CFG;
  assign hit_status = paddr == `PMP_OFF_STATUS;
  assign hit_ctrl   = paddr == `PMP_OFF_CTRL;
  assign hit_uid    = (paddr & `PMP_UID_MASK) == `PMP_OFF_UID0;
  assign uid_sel    = paddr[`PMP_UID_SEL_LSB +: 2];
  assign hit_any    = hit_cfg | hit_status | hit_ctrl | hit_uid;

  // Read mux; the configuration register has no write path at all.
  always_comb begin
    prdata_next = 14'h0000;
    if (hit_cfg) begin
      prdata_next = cfg_reg;
    end else if (hit_uid) begin
      prdata_next = uid_reg[uid_sel];
    end else if (hit_ctrl) begin
      prdata_next[`PMP_CTRL_SWEN] = swen_reg;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= `PMP_ZERO32;
    end else begin
      pready  <= apb_setup;
      pslverr <= apb_setup & ~hit_any;
      if (!apb_setup) begin
        prdata <= `PMP_ZERO32;
      end else if (hit_status) begin
        prdata <= {1'b0, pc_reg, 12'h000, ~lock_n_reg ? 1'b0 : 1'b1, lvp_entry,
                   ~cfg_reg.debug_n, refused_st_reg};
      end else begin
        prdata <= {18'h0_0000, prdata_next};
      end
    end
  end

  // Control and sticky status; a new refusal wins over a clear in the same cycle.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      swen_reg       <= 1'b0;
      refused_st_reg <= 1'b0;
    end else begin
      if (apb_wr && hit_ctrl) begin
        swen_reg <= pwdata[`PMP_CTRL_SWEN];
      end
      if (sw_req.valid && !sw_ok) begin
        refused_st_reg <= 1'b1;
      end else if (apb_wr && hit_status && pwdata[`PMP_ST_REFUSED]) begin
        refused_st_reg <= 1'b0;
      end
    end
  end

  // User ID words: running code over APB, the programmer when unlocked; erase sets ones.
  for (genvar u = 0; u < 4; u++) begin : g_uid
    always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
        uid_reg[u] <= `PMP_CFG_BLANK;
      end else if (ext_req.valid && ext_req.erase) begin
        uid_reg[u] <= `PMP_CFG_BLANK;
      end else if (ext_req.valid && ext_req.we && ext_is_uid && lock_n_reg
                   && ext_uid_sel == 2'(u)) begin
        uid_reg[u] <= ext_req.wdata;
      end else if (apb_wr && hit_uid && uid_sel == 2'(u)) begin
        uid_reg[u] <= pwdata[13:0];
      end
    end
  end

endmodule
`default_nettype wire

// ---- pmp_protect_monitor.sv ----
// Port-level checker for the program memory protection block.
// Assumes it is bound to pmp_protect and sees only that module's ports.
`timescale 1ns/1ns
`default_nettype none
module pmp_protect_monitor (
  input wire logic                  ref_clk,
  input wire logic                  rst_n,
  input wire logic [11:0]           fetch_addr,
  input wire logic                  irq_accept,
  input wire pmp_pkg::pmp_sw_req_t  sw_req,
  input wire logic                  sw_done,
  input wire logic                  sw_refused,
  input wire logic                  mem_we,
  input wire logic [11:0]           mem_waddr,
  input wire logic                  mem_he_region,
  input wire logic                  mem_bulk_erase,
  input wire pmp_pkg::pmp_ext_req_t ext_req,
  input wire logic                  lvp_entry,
  input wire logic                  ext_ack,
  input wire logic [13:0]           ext_rdata,
  input wire logic                  ext_refused,
  input wire logic                  external_access_lock_n,
  input wire logic                  nv_cfg_we,
  input wire logic [13:0]           nv_cfg_wdata,
  input wire logic                  debug_dedicated,
  input wire logic [1:0]            gpio_in,
  input wire logic [1:0]            dbg_in
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  // Fetch restarts at word zero and an accepted interrupt lands on word four.
  fetch_reset_a: assert property ($rose(rst_n) |-> fetch_addr == 12'h000)
    else $error("fetch not at reset vector");
  irq_vector_a: assert property (irq_accept |=> fetch_addr == 12'h004)
    else $error("fetch not at interrupt vector");
  // A locked array reads as zeros outward and refuses outside writes untouched.
  lock_read_a: assert property (!external_access_lock_n && ext_req.valid && !ext_req.we
    && !ext_req.erase && !ext_req.addr[15] |-> ##2 ext_ack && ext_rdata == 14'h0000)
    else $error("locked read leaked data");
  lock_write_a: assert property (!external_access_lock_n && ext_req.valid && ext_req.we
    && !ext_req.erase && !ext_req.addr[15] |=> !mem_we ##1 ext_refused)
    else $error("locked write not refused");
  // A self-write is answered once, and only a granted one reaches the array.
  sw_answer_a: assert property (sw_req.valid && !ext_req.we
    |=> (sw_done ^ sw_refused) && mem_we == sw_done)
    else $error("self-write answer wrong");
  he_region_a: assert property (mem_we |-> mem_he_region == (mem_waddr >= 12'hf80))
    else $error("endurance region flag wrong");
  // Bulk erase pulses the array and writes a blank configuration image.
  erase_blank_a: assert property (ext_req.valid && ext_req.erase
    |=> mem_bulk_erase && nv_cfg_we && nv_cfg_wdata == 14'h3fff)
    else $error("bulk erase not applied");
  lvp_keep_a: assert property (ext_req.valid && ext_req.we && ext_req.addr == 16'h8007
    && lvp_entry && !ext_req.wdata[13] |=> nv_cfg_we && nv_cfg_wdata[13] ##1 ext_refused)
    else $error("low-voltage enable was cleared");
  pin_side_a: assert property ((debug_dedicated ? gpio_in : dbg_in) == 2'h0)
    else $error("pin levels leak to the idle side");
endmodule
bind pmp_protect pmp_protect_monitor u_mon (
  .ref_clk, .rst_n, .fetch_addr, .irq_accept, .sw_req, .sw_done, .sw_refused, .mem_we,
  .mem_waddr, .mem_he_region, .mem_bulk_erase, .ext_req, .lvp_entry, .ext_ack, .ext_rdata,
  .ext_refused, .external_access_lock_n, .nv_cfg_we, .nv_cfg_wdata, .debug_dedicated,
  .gpio_in, .dbg_in
);
`default_nettype wire

// ---- pmp_prog_model.sv ----
// Behavioural external programmer: request strobes and the two serial pins.
// Assumes one bench process calls it, one request at a time.
`timescale 1ns/1ns
`default_nettype none
module pmp_prog_model (
  input  wire logic                  ref_clk,
  output var  pmp_pkg::pmp_ext_req_t ext_req,
  input  wire logic [1:0]            pin_o,
  input  wire logic [1:0]            pin_oe,
  output logic      [1:0]            pin_i
);
  // With both pins released there is no pull here, so each shows the inverse of the level last driven.
  assign pin_i = pin_oe ? pin_o : ~pin_o;
  initial ext_req = '0;
  // One-cycle strobe, then an idle cycle so no field is driven twice in a step.
  task automatic xfer(input logic we, input logic er, input logic [15:0] a,
                      input logic [13:0] d);
    ext_req <= '{valid: 1'b1, we: we, erase: er, addr: a, wdata: d};
    @(posedge ref_clk);
    ext_req <= '0;
    @(posedge ref_clk);
  endtask
endmodule
`default_nettype wire

// ---- test_program_memory_protection.sv ----
// Self-checking bench for the program memory protection block.
// Assumes the partner model and the bound checker are compiled ahead of it.
`timescale 1ns/1ns
`default_nettype none
module test_program_memory_protection;
  logic        ref_clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic        core_pc_inc = 1'b0, core_pc_load = 1'b0, irq_accept = 1'b0, lvp_entry = 1'b0;
  logic        external_access_lock_n = 1'b1;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [14:0] core_pc_target = 15'h0000;
  logic [13:0] cfg_nv_word = 14'h3602;
  pmp_pkg::pmp_sw_req_t  sw_req = '0;
  pmp_pkg::pmp_ext_req_t ext_req;
  logic [31:0] prdata, r;
  logic        pready, pslverr, sw_done, sw_refused, mem_we, mem_he_region, mem_bulk_erase;
  logic        ext_ack, ext_refused, nv_cfg_we, hv_prog_required, low_power_brownout_off_enable, debug_dedicated;
  logic        clk_o, clk_oe, dat_o, dat_oe;
  logic [11:0] fetch_addr, mem_waddr, ext_mem_addr;
  logic [13:0] mem_wdata, ext_rdata, ext_mem_rdata, nv_cfg_wdata;
  logic [1:0]  pin_i, gpio_in, dbg_in;
  logic [31:0] seed = 32'h0000_774c;
  logic [32:0] ae, apb_q[$];
  logic [15:0] ee, ext_q[$];
  logic [12:0] se, sw_q[$];
  int          num_errors = 0, n_compared = 0;

  pmp_protect dut (
    .ref_clk, .rst_n, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr,
    .core_pc_inc, .core_pc_load, .core_pc_target, .irq_accept, .fetch_addr, .sw_req, .sw_done,
    .sw_refused, .mem_we, .mem_waddr, .mem_wdata, .mem_he_region, .mem_bulk_erase, .ext_req,
    .lvp_entry, .ext_ack, .ext_rdata, .ext_refused, .ext_mem_addr, .ext_mem_rdata, .cfg_nv_word,
    .external_access_lock_n, .nv_cfg_we, .nv_cfg_wdata, .hv_prog_required, .low_power_brownout_off_enable,
    .debug_dedicated, .serial_prog_clock_pin_i(pin_i[0]), .serial_prog_clock_pin_o(clk_o),
    .serial_prog_clock_pin_oe(clk_oe), .serial_prog_data_pin_i(pin_i[1]),
    .serial_prog_data_pin_o(dat_o), .serial_prog_data_pin_oe(dat_oe), .gpio_out(2'h0),
    .gpio_oe(2'h0), .gpio_in, .dbg_out(2'h0), .dbg_oe(2'h0), .dbg_in
  );
  pmp_prog_model prog (.ref_clk, .ext_req, .pin_o({dat_o, clk_o}), .pin_oe({dat_oe, clk_oe}), .pin_i);

  // Free-running clock; the array answers at once with an address-derived pattern.
  always #50 ref_clk = ~ref_clk;
  assign ext_mem_rdata = {2'h2, ext_mem_addr ^ 12'h5a5};

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic test_done();
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // Bus cycle: setup, access held until pready, then an edge before the next one.
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    @(posedge ref_clk);
    while (pready !== 1'b1 && n < 20) begin
      @(posedge ref_clk);
      n++;
    end
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) begin
      chk("pready wait", 32'h0, 32'h1);
      test_done();
    end
    @(posedge ref_clk);
  endtask
  task automatic rd(input logic [11:0] a, input logic [32:0] e);
    apb_q.push_back(e);
    apb(1'b0, a, 32'h0000_0000);
  endtask
  task automatic ext(input logic w, input logic er, input logic [15:0] a, input logic [15:0] e);
    ext_q.push_back(e);
    prog.xfer(w, er, a, e[13:0]);
  endtask
  task automatic sw(input logic [14:0] a, input logic refuse);
    sw_q.push_back({refuse, a[11:0]});
    sw_req <= '{valid: 1'b1, addr: a, wdata: 14'h0155};
    @(posedge ref_clk);
    sw_req <= '0;
    @(posedge ref_clk);
  endtask
  task automatic pulse_reset();
    rst_n <= 1'b0;
    repeat (20) @(posedge ref_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge ref_clk);
  endtask

  // Each result is matched against the oldest note in the cycle it stands.
  always @(posedge ref_clk) begin
    if (psel && penable && pready === 1'b1 && !pwrite) begin
      ae = apb_q.pop_front();
      chk("pslverr", 32'(ae[32]), 32'(pslverr));
      if (!ae[32])
        chk("prdata", ae[31:0], prdata);
    end
    if (ext_ack === 1'b1) begin
      ee = ext_q.pop_front();
      chk("ext_refused", 32'(ee[14]), 32'(ext_refused));
      if (ee[15])
        chk("ext_rdata", 32'(ee[13:0]), 32'(ext_rdata));
    end
    if (sw_done === 1'b1 || sw_refused === 1'b1) begin
      se = sw_q.pop_front();
      chk("sw_refused", 32'(se[12]), 32'(sw_refused));
      if (!se[12]) begin
        chk("mem_waddr", 32'(se[11:0]), 32'(mem_waddr));
        chk("mem_wdata", 32'h155, 32'(mem_wdata));
      end
    end
  end

  // Main sequence: configuration, counter, self-writes, outside access, locked part.
  initial begin
    pulse_reset();
    chk("fetch_addr", 32'h0, 32'(fetch_addr));
    chk("low_power_brownout_off_enable", 32'h1, 32'(low_power_brownout_off_enable));
    chk("debug_dedicated", 32'h0, 32'(debug_dedicated));
    chk("hv_prog_required", 32'h0, 32'(hv_prog_required));
    rd(12'h000, {1'b0, 32'h0000_37fe});
    apb(1'b1, 12'h000, 32'h0000_0000);
    rd(12'h000, {1'b0, 32'h0000_37fe});
    rd(12'h018, {1'b0, 32'h0000_3fff});
    rd(12'h020, {1'b1, 32'h0000_0000});
    chk("gpio_in", 32'h3, 32'(gpio_in));
    $display("test config done");
    for (int i = 0; i < 5; i++) begin
      r = (i == 0) ? 32'h0000_7fff : rnd();
      core_pc_target <= r[14:0];
      core_pc_load <= 1'b1;
      @(posedge ref_clk);
      core_pc_load <= 1'b0;
      core_pc_inc <= 1'b1;
      @(posedge ref_clk);
      core_pc_inc <= 1'b0;
      chk("fetch_addr", 32'(r[11:0]), 32'(fetch_addr));
      @(posedge ref_clk);
      chk("fetch_addr", 32'(12'(r[11:0] + 12'h001)), 32'(fetch_addr));
    end
    irq_accept <= 1'b1;
    @(posedge ref_clk);
    irq_accept <= 1'b0;
    $display("test counter done");
    sw(15'h0300, 1'b1);
    rd(12'h004, {1'b0, 32'h0004_0009});
    apb(1'b1, 12'h004, 32'h0000_0001);
    rd(12'h004, {1'b0, 32'h0004_0008});
    apb(1'b1, 12'h008, 32'h0000_0001);
    sw(15'h01ff, 1'b1);
    sw(15'h7f90, 1'b0);
    for (int i = 0; i < 6; i++) begin
      r = rnd();
      sw(r[14:0], r[11:9] == 3'h0);
    end
    $display("test self-write done");
    ext(1'b0, 1'b0, 16'h7abc, {2'h2, 2'h2, 12'habc ^ 12'h5a5});
    ext(1'b1, 1'b0, 16'h0f90, 16'h0000);
    ext(1'b1, 1'b0, 16'h8001, 16'h1234);
    ext(1'b0, 1'b0, 16'h8001, 16'h9234);
    rd(12'h014, {1'b0, 32'h0000_1234});
    lvp_entry <= 1'b1;
    ext(1'b1, 1'b0, 16'h8007, 16'h4000);
    lvp_entry <= 1'b0;
    ext(1'b0, 1'b1, 16'h0000, 16'h0000);
    repeat (3) @(posedge ref_clk);
    rd(12'h014, {1'b0, 32'h0000_3fff});
    $display("test outside access done");
    external_access_lock_n <= 1'b0;
    pulse_reset();
    ext(1'b0, 1'b0, 16'h0123, 16'h8000);
    ext(1'b1, 1'b0, 16'h0123, 16'h4123);
    apb(1'b1, 12'h008, 32'h0000_0001);
    sw(15'h0400, 1'b0);
    irq_accept <= 1'b1;
    @(posedge ref_clk);
    irq_accept <= 1'b0;
    @(posedge ref_clk);
    chk("fetch_addr", 32'h0000_0004, 32'(fetch_addr));
    rd(12'h004, {1'b0, 32'h0004_0000});
    repeat (4) @(posedge ref_clk);
    $display("test locked part done");
    chk("notes left", 32'h0, 32'(apb_q.size() + ext_q.size() + sw_q.size()));
    test_done();
  end
endmodule
`default_nettype wire
